/* hw/cil_pkg.sv */
// Shared constants, types and ECC functions for the configuration integrity block
package cil_pkg;
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] CMD_OFS     = 8'h04;
    localparam logic [7:0] STATUS_OFS  = 8'h08;
    localparam logic [7:0] FADDR_OFS   = 8'h0C;
    localparam logic [7:0] FWDATA_OFS  = 8'h10;
    localparam logic [7:0] FRDATA_OFS  = 8'h14;
    localparam logic [7:0] PARAM_OFS   = 8'h18;
    localparam logic [7:0] WDTLD_OFS   = 8'h1C;
    localparam logic [7:0] GPIO_OFS    = 8'h20;
    localparam logic [7:0] BUSADR_OFS  = 8'h24;
    localparam logic [7:0] ACTCFG_OFS  = 8'h28;
    localparam logic [2:0] CTRL_RESET  = 3'h1;
    localparam logic [31:0] WDT_RESET  = 32'h0000_1000;
    localparam logic [31:0] PARAM_MIN  = 32'h0000_0010;
    localparam logic [31:0] PARAM_MAX  = 32'h0000_0FFF;
    localparam logic [31:0] PARAM_RESET = 32'h0000_0010;
    localparam logic [31:0] FACTORY_CFG = 32'h0000_0000;
    localparam logic [31:0] BLANK_WORD = 32'hFFFF_FFFF;
    localparam int AW = 6;
    localparam logic [5:0] FW_LAST  = 6'h0F;
    localparam logic [5:0] CFG_LAST = 6'h2F;
    localparam logic [5:0] LOG_LAST = 6'h3F;
    localparam logic [6:0] TAP_ADDR = 7'h7E;
    localparam logic [3:0] ADDR_MULT = 4'hC;
    localparam logic [3:0] IR_FADDR = 4'h1;
    localparam logic [3:0] IR_FDATA = 4'h2;
    localparam logic [3:0] IR_ERASE = 4'h3;
    localparam int CLK_MHZ      = 250;
    localparam int INIT_TIME_US = 20000;
    localparam int INIT_CYCLES  = INIT_TIME_US * CLK_MHZ;
    localparam int SLOW_PCT     = 90;

    typedef struct packed {
        logic       short_pin;
        logic       open_pin;
        logic [2:0] bin;
    } cil_strap_type;

    typedef struct packed {
        logic blank;
        logic param_rej;
        logic ecc_corr;
        logic log_en;
        logic busy;
        logic running;
        logic slow_clk;
        logic tap_en;
        logic log_ok;
        logic cfg_fault;
        logic cfg_ok;
        logic fw_ok;
    } cil_status_type;

    // Hamming code, check bits at positions 1,2,4,8,16,32 of 38
    function automatic logic [37:0] cil_ecc_encode(input logic [31:0] d);
        logic [37:0] cw;
        logic [5:0]  p;
        int          j;
        cw = '0;
        p  = '0;
        j  = 0;
        for (int i = 1; i <= 38; i++) begin
            if ((i & (i - 1)) != 0) begin
                cw[i-1] = d[j];
                j = j + 1;
                if (d[j-1]) p = p ^ 6'(i);
            end
        end
        for (int k = 0; k < 6; k++) cw[(1 << k) - 1] = p[k];
        return cw;
    endfunction

    // Corrects one flipped bit; two flips are not detected
    function automatic logic [32:0] cil_ecc_decode(input logic [37:0] cw_in);
        logic [37:0] cw;
        logic [31:0] d;
        logic [5:0]  s;
        int          j;
        cw = cw_in;
        s  = '0;
        j  = 0;
        d  = '0;
        for (int i = 1; i <= 38; i++) if (cw[i-1]) s = s ^ 6'(i);
        if (s != 6'h00 && s <= 6'd38) cw[s-1] = ~cw[s-1];
        for (int i = 1; i <= 38; i++) begin
            if ((i & (i - 1)) != 0) begin
                d[j] = cw[i-1];
                j = j + 1;
            end
        end
        return {s != 6'h00, d};
    endfunction
endpackage

/* hw/cil_flash_mem.sv */
// Configuration flash array with registered read data
module cil_flash_mem
    import cil_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [37:0]   wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [37:0]   rdata
);
    // Nonvolatile array powers up blank
    logic [37:0] mem [0:(1<<AW)-1] = '{default: cil_ecc_encode(BLANK_WORD)};

    always_ff @(posedge pclk) begin
        if (ce) begin
            if (we) mem[waddr] <= wdata;
            rdata <= mem[raddr];
        end
    end
endmodule

/* hw/cil_top.sv */
// Power-up integrity checks, flash ECC, watchdog and test-port enable
// Overview of operation
// - Test port off by default, pins are GPIO
// - Blank configuration store enables test port
// - Decoded bus address 126 enables test port
// - Shorted or open strap forces address 126
// - Test port mode requests 90% system clock
// - Test port programs flash only, no scan
// - Four shared pins serve as GPIO
// - Bad firmware checksum: halt, await bus commands
// - Bad configuration checksum loads factory default
// - Configuration mismatch raises alert and status flag
// - Error log checked by its own checksum
// - Watchdog expiry forces normal device reset
// - In reset GPIO open, fast PWM low
// - Parameter writes outside range are rejected
// - Each stored word gets six check bits
// - Single-bit flash errors corrected on read
// - After bus rewrite keep old config, logging off
// - Roughly 20 ms initialization before operation
module cil_top
    import cil_pkg::*;
#(
    parameter int INIT_CNT = cil_pkg::INIT_CYCLES
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire cil_pkg::cil_strap_type strap0,
    input  wire cil_pkg::cil_strap_type strap1,
    input  wire logic [3:0]    pin_in,
    output logic      [3:0]    pin_out,
    output logic      [3:0]    pin_oe,
    output logic               fast_pwm_pin,
    output logic               bus_alert_out,
    output logic               slow_clock_req
);
    import cil_pkg::*;

    typedef enum {ST_BOOT, ST_SCAN, ST_DECIDE, ST_INIT, ST_RUN, ST_HALT, ST_ERASE} cil_state_type;
    typedef enum {T_RST, T_IDLE, T_SELDR, T_CAPDR, T_SHDR, T_EX1DR, T_PADR, T_EX2DR, T_UPDR,
                  T_SELIR, T_CAPIR, T_SHIR, T_EX1IR, T_PAIR, T_EX2IR, T_UPIR} cil_tap_type;

    // Pin synchronisers: change accepted when stages two and three agree
    logic [3:0] s1, s2, s3, pin_f, pin_fd;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0; s2 <= '0; s3 <= '0; pin_f <= '0; pin_fd <= '0;
        end else if (ce) begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            pin_f <= (s2 & s3) | (pin_f & (s2 | s3));
            pin_fd <= pin_f;
        end
    end
    wire tck_rise = pin_f[0] & ~pin_fd[0];
    wire tck_fall = ~pin_f[0] & pin_fd[0];

    cil_state_type st, next_st;
    cil_tap_type   tap, next_tap;
    cil_status_type sts, next_sts;
    logic [2:0]  ctrl, next_ctrl;
    logic [AW-1:0] faddr, next_faddr, idx, next_idx, pos, next_pos, jaddr, next_jaddr;
    logic        vld, next_vld, rd_pend, next_rd_pend, mem_we, next_mem_we;
    logic [AW-1:0] mem_wa, next_mem_wa;
    logic [37:0] mem_wd, next_mem_wd, mem_rd;
    logic [31:0] fwdata, next_fwdata, frdata, next_frdata, param, next_param;
    logic [31:0] wdt_ld, next_wdt_ld, wdt_cnt, next_wdt_cnt, act_cfg, next_act_cfg;
    logic [31:0] sum_fw, next_sum_fw, sum_cfg, next_sum_cfg, sum_log, next_sum_log;
    logic [31:0] chk_fw, next_chk_fw, chk_cfg, next_chk_cfg, chk_log, next_chk_log;
    logic [31:0] cfg_first, next_cfg_first, init_cnt, next_init_cnt;
    logic [8:0]  gpio, next_gpio;
    logic [6:0]  bus_addr, next_bus_addr;
    logic [3:0]  ir, next_ir;
    logic [31:0] sr, next_sr, prdata_n;
    logic        tdo, next_tdo, pslverr_n;
    logic [3:0]  pin_out_n, pin_oe_n;
    logic [32:0] dec;
    logic [AW-1:0] raddr;
    logic        wr, rd, known, jt_prog, jt_erase;

    cil_flash_mem u_mem (
        .pclk  (pclk),
        .ce    (ce),
        .we    (mem_we),
        .waddr (mem_wa),
        .wdata (mem_wd),
        .raddr (raddr),
        .rdata (mem_rd)
    );

    assign raddr = (st == ST_SCAN) ? idx : faddr;
    assign dec   = cil_ecc_decode(mem_rd);
    assign wr    = psel & penable & pwrite;
    assign rd    = psel & ~penable & ~pwrite;

    // Test access state walk on each sampled clock rise
    always_comb begin
        next_tap = tap;
        next_ir  = ir;
        next_sr  = sr;
        next_tdo = tdo;
        jt_prog  = 1'b0;
        jt_erase = 1'b0;
        if (!sts.tap_en) begin
            next_tap = T_RST;
        end else if (tck_rise) begin
            case (tap)
                T_RST:   next_tap = pin_f[1] ? T_RST : T_IDLE;
                T_IDLE:  next_tap = pin_f[1] ? T_SELDR : T_IDLE;
                T_SELDR: next_tap = pin_f[1] ? T_SELIR : T_CAPDR;
                T_CAPDR: next_tap = pin_f[1] ? T_EX1DR : T_SHDR;
                T_SHDR:  next_tap = pin_f[1] ? T_EX1DR : T_SHDR;
                T_EX1DR: next_tap = pin_f[1] ? T_UPDR : T_PADR;
                T_PADR:  next_tap = pin_f[1] ? T_EX2DR : T_PADR;
                T_EX2DR: next_tap = pin_f[1] ? T_UPDR : T_SHDR;
                T_UPDR:  next_tap = pin_f[1] ? T_SELDR : T_IDLE;
                T_SELIR: next_tap = pin_f[1] ? T_RST : T_CAPIR;
                T_CAPIR: next_tap = pin_f[1] ? T_EX1IR : T_SHIR;
                T_SHIR:  next_tap = pin_f[1] ? T_EX1IR : T_SHIR;
                T_EX1IR: next_tap = pin_f[1] ? T_UPIR : T_PAIR;
                T_PAIR:  next_tap = pin_f[1] ? T_EX2IR : T_PAIR;
                T_EX2IR: next_tap = pin_f[1] ? T_UPIR : T_SHIR;
                T_UPIR:  next_tap = pin_f[1] ? T_SELDR : T_IDLE;
                default: next_tap = T_RST;
            endcase
            case (tap)
                T_RST:   next_ir = '0;
                T_CAPDR, T_CAPIR: next_sr = 32'h0000_0001;
                T_SHIR:  next_sr = {28'h000_0000, pin_f[2], sr[3:1]};
                T_UPIR:  next_ir = sr[3:0];
                // Only address and data paths exist; erase and all else is bypass
                T_SHDR: begin
                    case (ir)
                        IR_FADDR: next_sr = {26'h000_0000, pin_f[2], sr[5:1]};
                        IR_FDATA: next_sr = {pin_f[2], sr[31:1]};
                        default:  next_sr = {31'h0000_0000, pin_f[2]};
                    endcase
                end
                T_UPDR: begin
                    jt_prog  = (ir == IR_FDATA);
                    jt_erase = (ir == IR_ERASE);
                end
                default: next_sr = sr;
            endcase
        end else if (tck_fall) begin
            next_tdo = sr[0];
        end
    end

    // Main sequencing, flash access and register file
    always_comb begin
        next_st = st; next_sts = sts; next_ctrl = ctrl; next_faddr = faddr;
        next_idx = idx; next_pos = pos; next_vld = 1'b0; next_rd_pend = 1'b0;
        next_mem_we = 1'b0; next_mem_wa = mem_wa; next_mem_wd = mem_wd;
        next_fwdata = fwdata; next_frdata = frdata; next_param = param;
        next_wdt_ld = wdt_ld; next_wdt_cnt = wdt_cnt; next_act_cfg = act_cfg;
        next_sum_fw = sum_fw; next_sum_cfg = sum_cfg; next_sum_log = sum_log;
        next_chk_fw = chk_fw; next_chk_cfg = chk_cfg; next_chk_log = chk_log;
        next_cfg_first = cfg_first; next_init_cnt = init_cnt; next_gpio = gpio;
        next_bus_addr = bus_addr; next_jaddr = jaddr;
        known = 1'b1;
        prdata_n = 32'h0000_0000;
        case (paddr)
            CTRL_OFS:   prdata_n = {29'h0000_0000, ctrl};
            STATUS_OFS: prdata_n = {20'h0_0000, sts};
            FADDR_OFS:  prdata_n = {26'h000_0000, faddr};
            FWDATA_OFS: prdata_n = fwdata;
            FRDATA_OFS: prdata_n = frdata;
            PARAM_OFS:  prdata_n = param;
            WDTLD_OFS:  prdata_n = wdt_ld;
            GPIO_OFS:   prdata_n = {16'h0000, pin_f, 3'h0, gpio};
            BUSADR_OFS: prdata_n = {25'h000_0000, bus_addr};
            ACTCFG_OFS: prdata_n = act_cfg;
            CMD_OFS:    prdata_n = 32'h0000_0000;
            default:    known = 1'b0;
        endcase
        pslverr_n = ~known;
        if (wr) begin
            case (paddr)
                CTRL_OFS:   next_ctrl = pwdata[2:0];
                FADDR_OFS:  next_faddr = pwdata[AW-1:0];
                FWDATA_OFS: next_fwdata = pwdata;
                WDTLD_OFS:  next_wdt_ld = pwdata;
                GPIO_OFS:   next_gpio = pwdata[8:0];
                PARAM_OFS: begin
                    if (pwdata >= PARAM_MIN && pwdata <= PARAM_MAX) next_param = pwdata;
                    else next_sts.param_rej = 1'b1;
                end
                STATUS_OFS: begin
                    next_sts.cfg_fault = sts.cfg_fault & ~pwdata[2];
                    next_sts.ecc_corr  = sts.ecc_corr & ~pwdata[9];
                    next_sts.param_rej = sts.param_rej & ~pwdata[10];
                end
                default: next_ctrl = ctrl;
            endcase
        end
        if (rd_pend) begin
            next_frdata = dec[31:0];
            if (dec[32]) next_sts.ecc_corr = 1'b1;
        end
        case (st)
            ST_BOOT: begin
                // Strap capture after reset release, never under reset
                if (strap0.short_pin | strap0.open_pin | strap1.short_pin | strap1.open_pin)
                    next_bus_addr = TAP_ADDR;
                else
                    next_bus_addr = 7'(ADDR_MULT) * 7'(strap1.bin) + 7'(strap0.bin);
                next_idx = '0; next_sum_fw = '0; next_sum_cfg = '0; next_sum_log = '0;
                next_sts.blank = 1'b1;
                next_st = ST_SCAN;
            end
            ST_SCAN: begin
                next_idx = idx + 1'b1;
                next_pos = idx;
                next_vld = 1'b1;
                if (vld) begin
                    if (pos < FW_LAST) next_sum_fw = sum_fw + dec[31:0];
                    else if (pos == FW_LAST) next_chk_fw = dec[31:0];
                    else if (pos < CFG_LAST) next_sum_cfg = sum_cfg + dec[31:0];
                    else if (pos == CFG_LAST) next_chk_cfg = dec[31:0];
                    else if (pos < LOG_LAST) next_sum_log = sum_log + dec[31:0];
                    else next_chk_log = dec[31:0];
                    if (pos > FW_LAST && pos <= CFG_LAST && dec[31:0] != BLANK_WORD)
                        next_sts.blank = 1'b0;
                    if (pos == FW_LAST + 1'b1) next_cfg_first = dec[31:0];
                    if (pos == LOG_LAST) next_st = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                next_sts.fw_ok  = (sum_fw == chk_fw);
                next_sts.cfg_ok = (sum_cfg == chk_cfg);
                next_sts.log_ok = (sum_log == chk_log);
                next_act_cfg = (sum_cfg == chk_cfg) ? cfg_first : FACTORY_CFG;
                if (sum_cfg != chk_cfg) next_sts.cfg_fault = 1'b1;
                next_sts.tap_en   = sts.blank | (bus_addr == TAP_ADDR);
                next_sts.slow_clk = sts.blank | (bus_addr == TAP_ADDR);
                next_sts.log_en   = 1'b1;
                next_init_cnt = 32'(INIT_CNT - 1);
                next_st = ST_INIT;
            end
            ST_INIT: begin
                next_init_cnt = init_cnt - 1'b1;
                if (init_cnt == 32'h0000_0000) begin
                    next_st = sts.fw_ok ? ST_RUN : ST_HALT;
                    next_wdt_cnt = wdt_ld;
                end
            end
            ST_ERASE: begin
                next_mem_we = 1'b1;
                next_mem_wa = idx;
                next_mem_wd = cil_ecc_encode(BLANK_WORD);
                next_idx = idx + 1'b1;
                if (idx == LOG_LAST) next_st = sts.fw_ok ? ST_RUN : ST_HALT;
            end
            default: begin
                next_st = st;
            end
        endcase
        next_sts.running = (next_st == ST_RUN);
        next_sts.busy = (next_st == ST_ERASE);
        if (st == ST_RUN || st == ST_HALT || st == ST_INIT) begin
            if (wr && paddr == CMD_OFS) begin
                next_rd_pend = pwdata[0];
                if (pwdata[1] && !ctrl[0]) begin
                    next_idx = '0;
                    next_st = ST_ERASE;
                    next_sts.log_en = 1'b0;
                end else if (pwdata[2] && !ctrl[0]) begin
                    next_mem_we = 1'b1;
                    next_mem_wa = faddr;
                    next_mem_wd = cil_ecc_encode(fwdata) ^ {37'h0, ctrl[2]};
                    next_sts.log_en = 1'b0;
                end
            end
            // Test port programs regardless of write protection
            if (jt_erase) begin
                next_idx = '0;
                next_st = ST_ERASE;
            end else if (jt_prog) begin
                next_mem_we = 1'b1;
                next_mem_wa = jaddr;
                next_mem_wd = cil_ecc_encode(sr);
                next_jaddr = jaddr + 1'b1;
            end
            if (tck_rise && tap == T_UPDR && ir == IR_FADDR) next_jaddr = sr[AW-1:0];
        end
        if (st == ST_RUN && ctrl[1]) begin
            if (wr && paddr == CMD_OFS && pwdata[4]) next_wdt_cnt = wdt_ld;
            else next_wdt_cnt = wdt_cnt - 1'b1;
        end
        // Watchdog expiry or host reset restarts the whole power-up path
        if ((st == ST_RUN && ctrl[1] && wdt_cnt == 32'h0000_0000) ||
            (wr && paddr == CMD_OFS && pwdata[3])) begin
            next_st = ST_BOOT;
            next_gpio = '0;
            next_sts.running = 1'b0;
            next_sts.busy = 1'b0;
            next_sts.tap_en = 1'b0;
            next_sts.slow_clk = 1'b0;
        end
        // Shared pins: test port owns them when enabled, else GPIO in run or halt, released otherwise
        if (sts.tap_en) begin
            pin_out_n = {tdo, 3'h0};
            pin_oe_n  = {(tap == T_SHDR || tap == T_SHIR), 3'h0};
        end else if (st == ST_RUN || st == ST_HALT) begin
            pin_out_n = gpio[3:0];
            pin_oe_n  = gpio[7:4];
        end else begin
            pin_out_n = 4'h0;
            pin_oe_n  = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ST_BOOT; tap <= T_RST; sts <= '0; ctrl <= CTRL_RESET; faddr <= '0;
            idx <= '0; pos <= '0; vld <= 1'b0; rd_pend <= 1'b0; mem_we <= 1'b0;
            mem_wa <= '0; mem_wd <= '0; fwdata <= '0; frdata <= '0; param <= PARAM_RESET;
            wdt_ld <= WDT_RESET; wdt_cnt <= WDT_RESET; act_cfg <= FACTORY_CFG;
            sum_fw <= '0; sum_cfg <= '0; sum_log <= '0; chk_fw <= '0; chk_cfg <= '0;
            chk_log <= '0; cfg_first <= '0; init_cnt <= '0; gpio <= '0; bus_addr <= '0;
            jaddr <= '0; ir <= '0; sr <= '0; tdo <= 1'b0;
            prdata <= '0; pready <= 1'b0; pslverr <= 1'b0; pin_out <= '0; pin_oe <= '0;
            fast_pwm_pin <= 1'b0; bus_alert_out <= 1'b0; slow_clock_req <= 1'b0;
        end else if (ce) begin
            st <= next_st; tap <= next_tap; sts <= next_sts; ctrl <= next_ctrl;
            faddr <= next_faddr; idx <= next_idx; pos <= next_pos; vld <= next_vld;
            rd_pend <= next_rd_pend; mem_we <= next_mem_we; mem_wa <= next_mem_wa;
            mem_wd <= next_mem_wd; fwdata <= next_fwdata; frdata <= next_frdata;
            param <= next_param; wdt_ld <= next_wdt_ld; wdt_cnt <= next_wdt_cnt;
            act_cfg <= next_act_cfg; sum_fw <= next_sum_fw; sum_cfg <= next_sum_cfg;
            sum_log <= next_sum_log; chk_fw <= next_chk_fw; chk_cfg <= next_chk_cfg;
            chk_log <= next_chk_log; cfg_first <= next_cfg_first; init_cnt <= next_init_cnt;
            gpio <= next_gpio; bus_addr <= next_bus_addr; jaddr <= next_jaddr;
            ir <= next_ir; sr <= next_sr; tdo <= next_tdo;
            if (rd) prdata <= prdata_n;
            if (psel & ~penable) pslverr <= pslverr_n;
            pready <= 1'b1;
            pin_out <= pin_out_n;
            pin_oe <= pin_oe_n;
            fast_pwm_pin <= (st == ST_RUN) & gpio[8];
            bus_alert_out <= next_sts.cfg_fault;
            slow_clock_req <= next_sts.slow_clk;
        end
    end
endmodule

/* test/cil_top_assertions.sv */
// Port-level assertions for the configuration integrity block
module cil_top_assertions
    import cil_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  pin_oe,
    input wire logic        fast_pwm_pin,
    input wire logic        bus_alert_out,
    input wire logic        slow_clock_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd_setup;
    assign rd_setup = psel && !penable && !pwrite;
    access_ready_a: assert property (psel && penable |-> pready) else $error("pready low in access");
    release_quiet_a: assert property ($rose(presetn) |-> pin_oe == 4'h0 && !fast_pwm_pin)
        else $error("pins active at reset release");
    unmapped_err_a: assert property (psel && !penable && paddr > ACTCFG_OFS |=> pslverr)
        else $error("no error on unmapped address");
    mapped_ok_a: assert property (psel && !penable && paddr <= ACTCFG_OFS && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("error on mapped address");
    unmapped_zero_a: assert property (rd_setup && paddr > ACTCFG_OFS |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    read_hold_a: assert property (rd_setup ##1 penable |=> $stable(prdata)) else $error("read data moved");
    tap_pins_a: assert property (slow_clock_req |-> pin_oe[2:0] == 3'h0) else $error("port pins driven");
    alert_flag_a: assert property (rd_setup && paddr == STATUS_OFS && $stable(bus_alert_out)
        |=> prdata[2] == $past(bus_alert_out)) else $error("alert and flag differ");
    slow_flag_a: assert property (rd_setup && paddr == STATUS_OFS && $stable(slow_clock_req)
        |=> prdata[5] == $past(slow_clock_req)) else $error("slow clock flag differs");
    cover property ($rose(bus_alert_out));
    cover property ($rose(slow_clock_req));
    cover property ($fell(slow_clock_req));
endmodule

bind cil_top cil_top_assertions u_cil_top_assertions (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .pin_oe, .fast_pwm_pin, .bus_alert_out, .slow_clock_req);

/* test/cil_jtag_host.sv */
// Pin-side model: programmer on the test port and board levels on the shared pins
module cil_jtag_host (
    output logic [3:0]      pin_in,
    input wire logic [3:0]  pin_out,
    input wire logic [3:0]  pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] board = 4'h0;
    logic       tck = 1'b0;
    logic       in_frame = 1'b0;
    assign pin_in[3]   = pin_oe[3] ? pin_out[3] : board[3];
    // Clock stands low between frames; tms high keeps the port in its reset state
    assign pin_in[2:0] = in_frame ? {board[2], 1'b1, tck} : board[2:0];
    task automatic frame();
        in_frame = 1'b1;
        repeat (8) begin
            #62.5 tck = 1'b1;
            #62.5 tck = 1'b0;
        end
        in_frame = 1'b0;
    endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the configuration integrity block
module testbench;
    import cil_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic          fast_pwm_pin, bus_alert_out, slow_clock_req;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd, pexp, img [64];
    logic [31:0]   pv [4] = '{32'h0000_0FFF, 32'h0000_000F, 32'h0000_0010, 32'h0000_1000};
    logic [3:0]    pin_in, pin_out, pin_oe, g;
    cil_strap_type strap0, strap1;
    int            bad_count, n_checks, cycles, seed;
    cil_top #(.INIT_CNT(16)) u_cil_top (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .strap0, .strap1, .pin_in, .pin_out, .pin_oe, .fast_pwm_pin,
        .bus_alert_out, .slow_clock_req);
    cil_jtag_host u_cil_jtag_host (.pin_in, .pin_out, .pin_oe);
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask
    task automatic boot_wait();
        do apb(1'b0, STATUS_OFS, 32'h0); while (rd[2:1] == 2'b00);
        // Status may hold from the last boot, so also cover a full boot
        repeat (100) @(posedge pclk);
    endtask
    function automatic logic [31:0] csum(input int lo, input int hi);
        csum = '0;
        for (int i = lo; i < hi; i++) csum += img[i];
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        seed = $urandom(32'he1a3);
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        strap0 = '{1'b0, 1'b0, 3'($urandom_range(7))};
        strap1 = '{1'b0, 1'b0, 3'($urandom_range(7))};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        boot_wait();
        rd_chk(STATUS_OFS, 32'h0000_0877, 32'h0000_0834);
        check(32'(bus_alert_out), 32'h1);
        rd_chk(ACTCFG_OFS, '1, FACTORY_CFG);
        rd_chk(BUSADR_OFS, 32'h7F, 32'(12 * strap1.bin + strap0.bin));
        rd_chk(CTRL_OFS, 32'h7, 32'(CTRL_RESET));
        rd_chk(WDTLD_OFS, '1, WDT_RESET);
        rd_chk(PARAM_OFS, '1, PARAM_RESET);
        apb(1'b1, 8'h30, 32'h5);
        rd_chk(8'h30, '1, 32'h0);
        u_cil_jtag_host.frame();
        check(32'(pin_oe), 32'h0);
        pexp = PARAM_RESET;
        foreach (pv[i]) begin
            apb(1'b1, STATUS_OFS, 32'h400);
            apb(1'b1, PARAM_OFS, pv[i]);
            if (pv[i] >= PARAM_MIN && pv[i] <= PARAM_MAX) pexp = pv[i];
            rd_chk(STATUS_OFS, 32'h400, pexp == pv[i] ? 32'h0 : 32'h400);
            rd_chk(PARAM_OFS, '1, pexp);
        end
        apb(1'b1, CMD_OFS, 32'h2);
        rd_chk(STATUS_OFS, 32'h80, 32'h0);
        // Full update order: unprotect, erase, write, reset
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b1, CMD_OFS, 32'h2);
        rd_chk(STATUS_OFS, 32'h80, 32'h80);
        repeat (70) @(posedge pclk);
        foreach (img[i]) img[i] = $urandom();
        img[FW_LAST] = csum(0, 15);
        img[CFG_LAST] = csum(16, 47);
        img[LOG_LAST] = csum(48, 63);
        for (int i = 0; i < 64; i++) begin
            apb(1'b1, CTRL_OFS, i == 20 ? 32'h4 : 32'h0);
            apb(1'b1, FADDR_OFS, 32'(i));
            apb(1'b1, FWDATA_OFS, img[i]);
            apb(1'b1, CMD_OFS, 32'h4);
        end
        apb(1'b1, FADDR_OFS, 32'd20);
        apb(1'b1, CMD_OFS, 32'h1);
        @(posedge pclk);
        rd_chk(FRDATA_OFS, '1, img[20]);
        rd_chk(STATUS_OFS, 32'h300, 32'h200);
        rd_chk(ACTCFG_OFS, '1, FACTORY_CFG);
        apb(1'b1, STATUS_OFS, 32'h604);
        apb(1'b1, CMD_OFS, 32'h8);
        boot_wait();
        rd_chk(STATUS_OFS, 32'h0000_087F, 32'h0000_004B);
        rd_chk(ACTCFG_OFS, '1, img[16]);
        check(32'(bus_alert_out), 32'h0);
        g = 4'($urandom());
        u_cil_jtag_host.board = g;
        apb(1'b1, GPIO_OFS, 32'h100);
        rd_chk(GPIO_OFS, 32'hF000, 32'(g) << 12);
        apb(1'b1, GPIO_OFS, 32'h1F0 | 32'(~g));
        repeat (2) @(posedge pclk);
        check({pin_oe, pin_out, 3'h0, fast_pwm_pin}, {4'hF, ~g, 4'h1});
        strap0.short_pin <= 1'b1;
        apb(1'b1, WDTLD_OFS, 32'd40);
        apb(1'b1, CTRL_OFS, 32'h2);
        apb(1'b1, CMD_OFS, 32'h10);
        repeat (50) @(posedge pclk);
        check({pin_oe, 3'h0, fast_pwm_pin}, 8'h0);
        apb(1'b1, CTRL_OFS, 32'h0);
        boot_wait();
        rd_chk(BUSADR_OFS, 32'h7F, 32'h7E);
        rd_chk(STATUS_OFS, 32'h30, 32'h30);
        print_verdict();
    end
endmodule
